// ==== hw/enc_counter_pkg.sv ====
package enc_counter_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_HW_CONFIG    = 8'h65;
    localparam logic [7:0] IDX_STROBE       = 8'h67;
    localparam logic [7:0] IDX_PRESET       = 8'h68;
    localparam logic [7:0] IDX_COUNT        = 8'h69;
    localparam logic [7:0] IDX_REF_OFFSET   = 8'h6A;
    localparam logic [7:0] IDX_CONTROL      = 8'h6B;
    localparam logic [7:0] IDX_STATUS       = 8'h6C;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h70;
    localparam logic [7:0] IDX_IRQ_MASK     = 8'h71;

    // Hardware configuration fields
    localparam int HW_RELAY_BIT  = 0;
    localparam int HW_ZREF_BIT   = 2;
    localparam int HW_ABS_BIT    = 5;
    localparam int HW_CFG_W      = 8;

    // Control register fields
    localparam int CTL_W           = 24;
    localparam int CTL_STROBE_BIT  = 0;
    localparam int CTL_ZERO_BIT    = 3;
    localparam int CTL_REPZERO_BIT = 4;
    localparam int CTL_INHIBIT_BIT = 5;
    localparam int CTL_SETREF_BIT  = 6;
    localparam int CTL_OFFSET_BIT  = 10;
    localparam int CTL_GRAY_BIT    = 11;
    localparam int CTL_PAR_EN_BIT  = 12;
    localparam int CTL_PAR_ODD_BIT = 13;
    localparam logic [23:0] CTL_RESET = 24'h000300;

    // Status fields
    localparam int ST_VALID_BIT  = 0;
    localparam int ST_ZEROED_BIT = 3;
    localparam int ST_OVWR_BIT   = 4;
    localparam int ST_W          = 6;

    // Clock generator fields
    localparam int CG_DIV_MSB   = 9;
    localparam int CG_FRAME_LSB = 10;
    localparam int CG_FRAME_MSB = 15;

    localparam int CNT_W = 24;
    localparam int POS_W = 32;

    // Interrupt event bit positions
    localparam int EV_POS   = 0;
    localparam int EV_ZERO  = 1;
    localparam int EV_PERR  = 2;
    localparam int EV_W     = 3;

    typedef struct packed {
        logic [CNT_W-1:0] preset;
        logic [CNT_W-1:0] strobe;
        logic [CNT_W-1:0] ref_off;
    } cnt_regs_t;

    typedef enum logic [1:0] {
        SSI_IDLE  = 2'b00,
        SSI_CLOCK = 2'b01,
        SSI_DONE  = 2'b10,
        SSI_PAUSE = 2'b11
    } ssi_state_t;

endpackage

// ==== hw/encoder_counter_ssi_interface.sv ====
// Overview of operation
// - Relay bit one closes contact, zero opens
// - Config bit gates zero/reference input line
// - Config bit selects incremental or SSI absolute
// - Incremental strobe register reads back last write
// - Absolute mode: same location reads position word
// - Incremental count write loads stored preset value
// - Count read returns live incremental count
// - Absolute mode preset is 16-bit clock config
// - Low field divides module clock for SSI
// - Upper field holds twice pulses plus one
// - Reference/offset register used per control settings
// - Control register holds modes and filter
// - Status read clears flags except zeroed flag
// - Status bit zero marks valid position
// - Control bit selects binary or Gray decoding
`timescale 1ns/10ps
`default_nettype none
module encoder_counter_ssi_interface
    import enc_counter_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              enc_a,
    input  wire logic              enc_b,
    input  wire logic              zero_reference_input,
    input  wire logic              ssi_data,
    output logic                   ssi_clk,
    output logic                   relay_out,
    output logic                   irq
);

    // Two-stage synchronisers for all pins
    // Everything downstream reads only the second stage
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end else begin
            sync1_ff <= {ssi_data, zero_reference_input, enc_b, enc_a};
            sync2_ff <= sync1_ff;
        end
    end
    logic a_s;
    logic b_s;
    logic z_s;
    logic d_s;
    assign {d_s, z_s, b_s, a_s} = sync2_ff;

    // Register storage
    logic [HW_CFG_W-1:0] hw_cfg_ff;
    logic [CTL_W-1:0]    ctl_ff;
    cnt_regs_t           regs_ff;
    logic [CNT_W-1:0]    count_ff;
    logic [POS_W-1:0]    pos_ff;
    logic [ST_W-1:0]     status_ff;
    logic [EV_W-1:0]     irq_st_ff;
    logic [EV_W-1:0]     irq_mask_ff;

    // APB decode: zero wait states, unmapped addresses answer with an error
    // pready is tied high, so every access ends in its first access cycle
    logic       wr_en;
    logic       rd_en;
    logic       hit;
    logic [7:0] idx;
    assign idx    = paddr[9:2];
    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & penable & ~pwrite;
    assign pready = 1'b1;
    always_comb begin
        unique case (idx)
            IDX_HW_CONFIG, IDX_STROBE, IDX_PRESET, IDX_COUNT, IDX_REF_OFFSET,
            IDX_CONTROL, IDX_STATUS, IDX_IRQ_STATUS, IDX_IRQ_MASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & (~hit | paddr[1:0] != 2'b00
                     | paddr[ADDR_W-1:10] != '0);

    // Write strobe for one register; refused accesses never land
    function automatic logic wr_to(input logic [7:0] i);
        return wr_en && idx == i && !pslverr;
    endfunction

    // Encoder type switches the meaning of strobe, preset and count
    logic abs_mode;
    assign abs_mode = hw_cfg_ff[HW_ABS_BIT];

    // Hardware configuration and control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_cfg_ff <= '0;
            ctl_ff    <= CTL_RESET;
        end else begin
            if (wr_to(IDX_HW_CONFIG))
                hw_cfg_ff <= pwdata[HW_CFG_W-1:0];
            if (wr_to(IDX_CONTROL))
                ctl_ff <= pwdata[CTL_W-1:0];
        end
    end
    assign relay_out = hw_cfg_ff[HW_RELAY_BIT];

    // Preset doubles as the SSI clock generator; strobe and reference are plain storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs_ff <= '0;
        end else begin
            if (wr_to(IDX_PRESET))
                regs_ff.preset <= abs_mode ? {8'h00, pwdata[CG_FRAME_MSB:0]}
                                           : pwdata[CNT_W-1:0];
            if (wr_to(IDX_STROBE) && !abs_mode)
                regs_ff.strobe <= pwdata[CNT_W-1:0];
            if (wr_to(IDX_REF_OFFSET))
                regs_ff.ref_off <= pwdata[CNT_W-1:0];
        end
    end

    // Quadrature decode, 4-fold; counting stops when inputs are inhibited
    // Both pins changing in one sample is a lost step, so the pins must
    // hold each state for at least one clock after the synchronisers
    logic a_d_ff;
    logic b_d_ff;
    logic step;
    logic up;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_d_ff <= 1'b0;
            b_d_ff <= 1'b0;
        end else begin
            a_d_ff <= a_s;
            b_d_ff <= b_s;
        end
    end
    assign step = (a_s ^ a_d_ff) ^ (b_s ^ b_d_ff);
    assign up   = a_d_ff ^ b_s;

    // Gated zero/reference event: enabled by config bit, in incremental mode only
    // Only the rising edge counts, so a held level acts once
    logic z_d_ff;
    logic z_event;
    logic zero_req;
    logic setref_req;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            z_d_ff <= 1'b0;
        else
            z_d_ff <= z_s;
    end
    assign z_event    = z_s & ~z_d_ff & hw_cfg_ff[HW_ZREF_BIT] & ~abs_mode;
    assign zero_req   = z_event & (ctl_ff[CTL_ZERO_BIT] | ctl_ff[CTL_REPZERO_BIT]);
    assign setref_req = z_event & ctl_ff[CTL_SETREF_BIT];

    // Live counter; a software write wins over encoder steps
    // Order: software load, reference load, zeroing, then steps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
        end else if (wr_to(IDX_COUNT) && !abs_mode) begin
            count_ff <= regs_ff.preset;
        end else if (setref_req) begin
            count_ff <= regs_ff.ref_off;
        end else if (zero_req) begin
            count_ff <= '0;
        end else if (step && !ctl_ff[CTL_INHIBIT_BIT] && !abs_mode) begin
            count_ff <= up ? count_ff + 1'b1 : count_ff - 1'b1;
        end
    end

    // SSI engine: half-period counter from low field, edge count from upper field
    // A frame is F toggles of D+1 clocks, the first one falling; data is
    // taken on each rising toggle, then one latch cycle and a pause of
    // (F+1)*(D+1) clocks lets the encoder's monoflop expire.
    // Settings are read live, so a change mid-frame can garble one word;
    // software should discard the first position after reconfiguring.
    ssi_state_t        state_ff;
    logic [CG_DIV_MSB:0]              div_ff;
    logic [CG_FRAME_MSB-CG_FRAME_LSB:0] edge_ff;
    logic [POS_W-1:0]  shift_ff;
    logic              sclk_ff;
    logic              frame_done;
    logic [CG_DIV_MSB:0]              div_cfg;
    logic [CG_FRAME_MSB-CG_FRAME_LSB:0] frame_cfg;
    assign div_cfg   = regs_ff.preset[CG_DIV_MSB:0];
    assign frame_cfg = regs_ff.preset[CG_FRAME_MSB:CG_FRAME_LSB];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SSI_IDLE;
            div_ff   <= '0;
            edge_ff  <= '0;
            shift_ff <= '0;
            sclk_ff  <= 1'b1;
        end else begin
            unique case (state_ff)
                SSI_IDLE: begin
                    sclk_ff <= 1'b1;
                    if (abs_mode && frame_cfg > 6'h01) begin
                        state_ff <= SSI_CLOCK;
                        div_ff   <= div_cfg;
                        edge_ff  <= frame_cfg - 6'h01;
                        shift_ff <= '0;
                    end
                end
                SSI_CLOCK: begin
                    if (div_ff == '0) begin
                        div_ff  <= div_cfg;
                        sclk_ff <= ~sclk_ff;
                        // Sample on rising edge, MSB arrives first
                        if (!sclk_ff)
                            shift_ff <= {shift_ff[POS_W-2:0], d_s};
                        if (edge_ff == '0)
                            state_ff <= SSI_DONE;
                        else
                            edge_ff <= edge_ff - 6'h01;
                    end else begin
                        div_ff <= div_ff - 1'b1;
                    end
                end
                SSI_DONE: begin
                    sclk_ff  <= 1'b1;
                    state_ff <= SSI_PAUSE;
                    edge_ff  <= frame_cfg; // Monoflop pause reuses edge counter
                    div_ff   <= div_cfg;
                end
                SSI_PAUSE: begin
                    // Let the encoder monoflop time out before the next burst
                    if (div_ff == '0) begin
                        div_ff <= div_cfg;
                        if (edge_ff == '0)
                            state_ff <= SSI_IDLE;
                        else
                            edge_ff <= edge_ff - 6'h01;
                    end else begin
                        div_ff <= div_ff - 1'b1;
                    end
                end
            endcase
        end
    end
    assign ssi_clk    = sclk_ff;
    assign frame_done = state_ff == SSI_DONE;

    // Word decode: parity bit trails data when enabled
    logic [POS_W-1:0] raw_word;
    logic [POS_W-1:0] dec_word;
    logic             par_ok;
    always_comb begin
        raw_word = ctl_ff[CTL_PAR_EN_BIT] ? {1'b0, shift_ff[POS_W-1:1]} : shift_ff;
        dec_word = raw_word;
        // Gray to binary runs from the top bit down
        if (ctl_ff[CTL_GRAY_BIT]) begin
            for (int i = POS_W - 2; i >= 0; i--)
                dec_word[i] = dec_word[i+1] ^ raw_word[i];
        end
        // Parity covers the data bits and the parity bit itself
        par_ok = !ctl_ff[CTL_PAR_EN_BIT] ||
                 ((^shift_ff) == ctl_ff[CTL_PAR_ODD_BIT]);
    end

    // Latch position word when the frame is clean
    // A frame with a parity error keeps the previous position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pos_ff <= '0;
        else if (frame_done && par_ok)
            pos_ff <= dec_word;
    end

    // Status flags; set wins over the clear-on-read
    // Overwrite flag: a new word arrived while valid was still set
    logic st_rd;
    logic [ST_W-1:0] st_set;
    assign st_rd = rd_en && idx == IDX_STATUS && !pslverr;
    always_comb begin
        st_set = '0;
        st_set[ST_VALID_BIT]  = frame_done & par_ok;
        st_set[ST_OVWR_BIT]   = frame_done & par_ok & status_ff[ST_VALID_BIT];
        st_set[ST_ZEROED_BIT] = zero_req;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            status_ff <= '0;
        else if (st_rd)
            status_ff <= st_set | (status_ff & (ST_W'(1) << ST_ZEROED_BIT));
        else
            status_ff <= status_ff | st_set;
    end

    // Interrupt status, write one to clear; new events win
    // The mask only gates the output; status bits record every event
    logic [EV_W-1:0] ev;
    assign ev = {frame_done & ~par_ok, zero_req, frame_done & par_ok};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_ff   <= '0;
            irq_mask_ff <= '0;
        end else begin
            if (wr_to(IDX_IRQ_MASK))
                irq_mask_ff <= pwdata[EV_W-1:0];
            if (wr_to(IDX_IRQ_STATUS))
                irq_st_ff <= (irq_st_ff & ~pwdata[EV_W-1:0]) | ev;
            else
                irq_st_ff <= irq_st_ff | ev;
        end
    end
    assign irq = |(irq_st_ff & irq_mask_ff);

    // Read mux; strobe location and preset change meaning with mode
    // Bits above a register's width read as zero
    always_comb begin
        prdata = '0;
        if (rd_en && !pslverr) begin
            unique case (idx)
                IDX_HW_CONFIG:  prdata = {24'h0, hw_cfg_ff};
                IDX_STROBE:     prdata = abs_mode ? pos_ff : {8'h0, regs_ff.strobe};
                IDX_PRESET:     prdata = {8'h0, regs_ff.preset};
                IDX_COUNT:      prdata = {8'h0, count_ff};
                IDX_REF_OFFSET: prdata = {8'h0, regs_ff.ref_off};
                IDX_CONTROL:    prdata = {8'h0, ctl_ff};
                IDX_STATUS:     prdata = {26'h0, status_ff};
                IDX_IRQ_STATUS: prdata = {29'h0, irq_st_ff};
                IDX_IRQ_MASK:   prdata = {29'h0, irq_mask_ff};
                default:        prdata = '0;
            endcase
        end
    end

endmodule // encoder_counter_ssi_interface
`default_nettype wire

// ==== tb/enc_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module enc_monitor
    import enc_counter_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              relay_out,
    input wire logic              irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Aligned access-phase decode shared by the properties
    logic       acc;
    logic [7:0] ix;
    logic [7:0] hw_ff;
    assign acc = psel && penable && paddr[1:0] == 2'b00 && paddr[ADDR_W-1:10] == '0;
    assign ix  = paddr[9:2];

    // Shadow of the config register, so read-back does not hang on bus spacing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_ff <= 8'h00;
        end else if (acc && pwrite && ix == IDX_HW_CONFIG) begin
            hw_ff <= pwdata[7:0];
        end
    end

    chk_ready_high: assert property (pready) else $error("pready dropped");
    chk_rdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0)
        else $error("read data outside access");
    chk_err_align: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    chk_err_unmapped: assert property (acc && ix == 8'h66 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_ok_mapped: assert property (acc && ix == IDX_HW_CONFIG |-> !pslverr)
        else $error("mapped access refused");
    chk_relay_follow: assert property (acc && pwrite && ix == IDX_HW_CONFIG
        |=> relay_out == $past(pwdata[HW_RELAY_BIT])) else $error("relay not following");
    chk_hw_readback: assert property (acc && !pwrite && ix == IDX_HW_CONFIG
        |-> (prdata[7:0] & 8'h25) == (hw_ff & 8'h25)) else $error("config read-back");
    chk_irq_masked: assert property (acc && pwrite && ix == IDX_IRQ_MASK
        && pwdata[2:0] == 3'b000 |=> !irq [*2]) else $error("masked irq high");
    chk_zero_kept: assert property (acc && !pwrite && ix == IDX_STATUS
        && prdata[ST_ZEROED_BIT] ##[1:4] acc && !pwrite && ix == IDX_STATUS
        |-> prdata[ST_ZEROED_BIT]) else $error("zeroed flag lost on read");
endmodule // enc_monitor

bind encoder_counter_ssi_interface enc_monitor #(.ADDR_W(ADDR_W)) enc_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .relay_out(relay_out), .irq(irq));
`default_nettype wire

// ==== tb/enc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module enc_model (
    input  wire logic ssi_clk,
    output logic      ssi_data,
    output logic      enc_a,
    output logic      enc_b
);
    logic [31:0] word;
    logic [1:0]  ph;
    int          nbits;
    int          bits;
    realtime     t_fall;
    realtime     t_rise;
    realtime     half_ns;
    initial begin
        ssi_data = 1'b1;
        {enc_a, enc_b} = 2'b00;
        ph = 2'b00;
        word = 32'h0;
        nbits = 0;
        bits = 0;
        t_rise = 0;
    end
    // A long clock-high gap is the monoflop time, so a new frame starts
    always @(negedge ssi_clk) begin
        if ($realtime - t_rise > 500) begin
            bits = 0;
        end
        ssi_data = (bits < nbits) ? word[nbits-1-bits] : 1'b1;
        bits++;
        t_fall = $realtime;
    end
    // Low phase length, read by the bench to check the divider; the short
    // low before the stop rise at the end of a frame is left out
    always @(posedge ssi_clk) begin
        t_rise = $realtime;
        if (bits <= nbits)
            half_ns = t_rise - t_fall;
    end
    task automatic frame(input logic [31:0] w, input int n);
        word = w;
        nbits = n;
    endtask
    // One quadrature step per link period; B leads A when counting up
    task automatic move(input int n);
        repeat (n < 0 ? -n : n) begin
            #125;
            ph = (n < 0) ? ph - 2'b01 : ph + 2'b01;
            {enc_a, enc_b} = {ph[1], ph[1] ^ ph[0]};
        end
    endtask
endmodule // enc_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
    import enc_counter_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, zero_ref, err;
    logic        pready, pslverr, enc_a, enc_b, ssi_data, ssi_clk, relay_out, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          err_count = 0;
    int          checks_done = 0;
    int          cyc = 0;

    initial begin
        {pclk, presetn, psel, penable, pwrite, zero_ref} = 6'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    always #5 pclk = ~pclk;

    encoder_counter_ssi_interface encoder_counter_ssi_interface_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enc_a(enc_a), .enc_b(enc_b), .zero_reference_input(zero_ref), .ssi_data(ssi_data),
        .ssi_clk(ssi_clk), .relay_out(relay_out), .irq(irq));
    enc_model enc_model_inst (.ssi_clk(ssi_clk), .ssi_data(ssi_data), .enc_a(enc_a),
        .enc_b(enc_b));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard; the whole sequence needs about two thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, entered right after a rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Wait for ready however long it takes; the hang guard ends a stall
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] ix, input logic [31:0] d);
        apb({2'b00, ix, 2'b00}, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] ix);
        apb({2'b00, ix, 2'b00}, 1'b0, 32'h0);
    endtask
    task automatic step(input int n);
        enc_model_inst.move(n);
        repeat (8) @(posedge pclk);
    endtask
    task automatic pulse;
        zero_ref <= 1'b1;
        repeat (6) @(posedge pclk);
        zero_ref <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    // Two latch events, so a frame cut by a setting change is discarded
    task automatic frame_pos(input logic [31:0] exp);
        repeat (2) begin
            for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge pclk);
            chk("irq", {31'h0, irq}, 32'h1);
            wr(IDX_IRQ_STATUS, 32'h1);
        end
        rd(IDX_STROBE);
        chk("position", q, exp);
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(IDX_CONTROL);
        chk("control", q, 32'h300);
        wr(IDX_REF_OFFSET, 32'hABCDEF);
        rd(IDX_REF_OFFSET);
        chk("ref_offset", q, 32'hABCDEF);
        wr(IDX_HW_CONFIG, 32'h1);
        chk("relay", {31'h0, relay_out}, 32'h1);
        wr(IDX_STROBE, 32'h123456);
        rd(IDX_STROBE);
        chk("strobe", q, 32'h123456);
        wr(IDX_PRESET, 32'hFF00);
        wr(IDX_COUNT, 32'h0);
        rd(IDX_COUNT);
        chk("count", q, 32'hFF00);
        step(10);
        rd(IDX_COUNT);
        chk("count", q, 32'hFF0A);
        step(-3);
        rd(IDX_COUNT);
        chk("count", q, 32'hFF07);
        apb(12'h198, 1'b0, 32'h0);
        chk("unmapped", {err, q[30:0]}, 32'h80000000);
        apb(12'h1A6, 1'b0, 32'h0);
        chk("misaligned", {31'h0, err}, 32'h1);
        // Zeroing from the reference input, blocked then allowed
        wr(IDX_CONTROL, 32'h308);
        wr(IDX_IRQ_MASK, 32'h0);
        wr(IDX_HW_CONFIG, 32'h0);
        chk("relay", {31'h0, relay_out}, 32'h0);
        pulse();
        rd(IDX_COUNT);
        chk("count", q, 32'hFF07);
        wr(IDX_HW_CONFIG, 32'h4);
        rd(IDX_HW_CONFIG);
        chk("hw_config", q, 32'h4);
        pulse();
        rd(IDX_COUNT);
        chk("count", q, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        repeat (2) begin
            rd(IDX_STATUS);
            chk("zeroed", {31'h0, q[ST_ZEROED_BIT]}, 32'h1);
        end
        wr(IDX_IRQ_MASK, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(IDX_IRQ_STATUS, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        // Absolute mode: 12 data pulses, frame 25, divider 3
        wr(IDX_CONTROL, 32'h300);
        wr(IDX_IRQ_MASK, 32'h1);
        enc_model_inst.frame(32'hA5C, 12);
        wr(IDX_PRESET, 32'h6403);
        wr(IDX_HW_CONFIG, 32'h20);
        frame_pos(32'hA5C);
        rd(IDX_STATUS);
        chk("valid", {31'h0, q[ST_VALID_BIT]}, 32'h1);
        chk("ssi half period", int'(enc_model_inst.half_ns), 32'h28);
        wr(IDX_CONTROL, 32'hB00);
        frame_pos(32'hC68);
        // Even parity trails 12 data bits: 13 pulses, frame 27
        wr(IDX_CONTROL, 32'h1300);
        enc_model_inst.frame(32'h14B8, 13);
        wr(IDX_PRESET, 32'h6C03);
        frame_pos(32'hA5C);
        // Odd parity now fails every frame; position must be kept
        wr(IDX_CONTROL, 32'h3300);
        wr(IDX_IRQ_MASK, 32'h4);
        for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge pclk);
        chk("parity error", {31'h0, irq}, 32'h1);
        rd(IDX_STROBE);
        chk("position", q, 32'hA5C);
        end_sim();
    end
endmodule // tb
`default_nettype wire
